/* File: cpu_state_pipeline_control.sv */
// Purpose: Instruction state, fetch and pipeline control of the core
// Assumes: Decoder supplies branch kinds; memories answer in one cycle
// Notes: Stage occupancy is tracked as valid bits only
`include "pipe_consts.svh"
module cpu_state_pipeline_control
    import pipe_pkg::*;
(
    input wire logic i_mclk,            // Core clock
    input wire logic i_rst_n,           // Async reset, low
    input wire logic i_ibus_ready,      // Instruction bus done
    input wire logic i_bx,              // branch_exchange seen
    input wire logic i_blx,             // branch_link_exchange
    input wire logic i_pc_load,         // Load into pc done
    input wire logic i_bytecode_br,     // branch_to_bytecode_state
    input wire logic i_target_lsb,      // Target bit 0 selects compact
    input wire logic [31:0] i_target,   // Branch target
    input wire logic i_exc,             // Exception request
    input wire logic i_exc_ret,         // Exception return
    input wire logic [3:0] i_src,       // Decode source reg
    input wire logic i_src_vld,         // Source used
    input wire logic [3:0] i_ex_dst,    // Execute target
    input wire logic i_ex_wr,           // Execute writes
    input wire logic i_ex_load,         // Execute is load
    input wire logic [3:0] i_mem_dst,   // Memory target
    input wire logic i_mem_wr,          // Memory writes
    input wire logic i_dreq,            // Data request
    input wire logic [31:0] i_daddr,    // Data address
    input wire size_t i_dsize,          // Data size
    input wire logic [31:0] i_dwdata,   // Data write value
    output logic [31:0] o_iaddr,        // Fetch address
    output logic o_ireq,                // Fetch request
    output logic o_iword,               // Fetch is whole word
    output istate_t o_state,            // Current state
    output logic o_in_exc,              // In exception handler
    output logic o_flush,               // Pipeline flush
    output logic o_stall,               // Hazard stall
    output logic [1:0] o_fwd,           // Forward select
    output logic [5:0] o_stage_vld,     // Stage valid bits
    output logic o_dec2,                // Second decode cycle
    output logic [31:0] o_daddr,        // Data address out
    output logic [3:0] o_dbe,           // Data byte enables
    output logic [31:0] o_dwdata,       // Data write out
    output logic o_dmisalign            // Misaligned data request
);
    typedef enum logic [2:0] {
        RUN = 3'h1,
        REFILL = 3'h2,
        HANDLER = 3'h4
    } phase_t;

    typedef struct packed {
        phase_t phase;
        istate_t state;
        istate_t saved;
        logic in_exc;
        logic [31:0] pc;
        logic [5:0] vld;
        logic dec2;
        logic flush;
        logic [31:0] daddr;
        logic [3:0] dbe;
        logic [31:0] dwdata;
        logic dmis;
    } regs_t;

    regs_t r_q, r_d;
    logic hz_stall;
    logic [1:0] hz_fwd;
    logic [3:0] al_be;
    logic [31:0] al_wdata;
    logic al_mis;

    function automatic logic [31:0] step(input istate_t s);
        unique case (s)
            `ST_COMPACT: step = `COMPACT_STEP;
            default: step = `WIDE_STEP;
        endcase
    endfunction

    function automatic logic [31:0] align_pc(input istate_t s,
                                             input logic [31:0] a);
        unique case (s)
            `ST_WIDE: align_pc = {a[31:2], 2'h0};
            `ST_COMPACT: align_pc = {a[31:1], 1'h0};
            default: align_pc = a;
        endcase
    endfunction

    hazard_unit u_hz (
        .i_src(i_src),
        .i_src_vld(i_src_vld),
        .i_ex_dst(i_ex_dst),
        .i_ex_wr(i_ex_wr),
        .i_ex_load(i_ex_load),
        .i_mem_dst(i_mem_dst),
        .i_mem_wr(i_mem_wr),
        .o_stall(hz_stall),
        .o_fwd(hz_fwd)
    );

    data_align u_al (
        .i_addr_lo(i_daddr[1:0]),
        .i_size(i_dsize),
        .i_wdata(i_dwdata),
        .o_be(al_be),
        .o_wdata(al_wdata),
        .o_misalign(al_mis)
    );

    always_comb begin
        r_d = r_q;
        r_d.flush = 1'b0;
        r_d.daddr = i_daddr;
        r_d.dbe = i_dreq ? al_be : 4'h0;
        r_d.dwdata = al_wdata;
        r_d.dmis = i_dreq & al_mis;
        // Advance stages unless stalled
        if (!hz_stall) begin
            if (r_q.state == `ST_BYTE) begin
                if (r_q.vld[1] && !r_q.dec2) begin
                    r_d.dec2 = 1'b1;
                    r_d.vld = {r_q.vld[5:2], 1'b0, 1'b0} << 1;
                    r_d.vld[1] = 1'b0;
                    r_d.vld[2] = 1'b0;
                    r_d.vld[5:3] = r_q.vld[4:2];
                    r_d.vld[1] = 1'b1;
                    r_d.vld[0] = 1'b0;
                end else begin
                    r_d.dec2 = 1'b0;
                    r_d.vld = {r_q.vld[4:0], i_ibus_ready};
                end
            end else begin
                r_d.dec2 = 1'b0;
                r_d.vld = {1'b0, r_q.vld[3:0], i_ibus_ready};
            end
            if (i_ibus_ready && !(r_q.state == `ST_BYTE && r_q.vld[1]
                                  && !r_q.dec2)) begin
                r_d.pc = r_q.pc + step(r_q.state);
            end
        end
        r_d.phase = (r_q.phase == REFILL) ?
                    (r_q.in_exc ? HANDLER : RUN) : r_q.phase;
        if (i_exc && !r_q.in_exc) begin
            r_d.saved = r_q.state;
            r_d.state = `ST_WIDE;
            r_d.in_exc = 1'b1;
            r_d.pc = `EXC_VECTOR;
            r_d.vld = 6'h0;
            r_d.dec2 = 1'b0;
            r_d.flush = 1'b1;
            r_d.phase = REFILL;
        end else if (i_exc_ret && r_q.in_exc) begin
            r_d.state = r_q.saved;
            r_d.in_exc = 1'b0;
            r_d.pc = align_pc(r_q.saved, i_target);
            r_d.vld = 6'h0;
            r_d.dec2 = 1'b0;
            r_d.flush = 1'b1;
            r_d.phase = REFILL;
        end else if ((i_bx || i_blx || i_pc_load)
                     && r_q.state != `ST_BYTE) begin
            r_d.state = i_target_lsb ? `ST_COMPACT : `ST_WIDE;
            r_d.pc = align_pc(r_d.state, i_target);
            r_d.vld = 6'h0;
            r_d.dec2 = 1'b0;
            r_d.flush = 1'b1;
            r_d.phase = REFILL;
        end else if (i_bytecode_br && r_q.state != `ST_COMPACT) begin
            r_d.state = (r_q.state == `ST_WIDE) ? `ST_BYTE : `ST_WIDE;
            r_d.pc = i_target;
            r_d.vld = 6'h0;
            r_d.dec2 = 1'b0;
            r_d.flush = 1'b1;
            r_d.phase = REFILL;
        end
        // Handler never leaves wide state
        if (r_d.in_exc) begin
            r_d.state = `ST_WIDE;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_q <= '{phase: RUN, state: `ST_WIDE, saved: `ST_WIDE,
                     in_exc: 1'b0, pc: `RESET_PC, vld: 6'h0, dec2: 1'b0,
                     flush: 1'b0, daddr: 32'h0, dbe: 4'h0,
                     dwdata: 32'h0, dmis: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    always_comb begin
        unique case (r_q.state)
            `ST_WIDE: o_iaddr = {r_q.pc[31:2], 2'h0};
            `ST_COMPACT: o_iaddr = {r_q.pc[31:1], 1'h0};
            default: o_iaddr = {r_q.pc[31:2], 2'h0};
        endcase
    end

    // Byte pointer kept in pc; fetch is word wide in every state
    assign o_iword = 1'b1;
    assign o_ireq = !hz_stall;
    assign o_state = r_q.state;
    assign o_in_exc = r_q.in_exc;
    assign o_flush = r_q.flush;
    assign o_stall = hz_stall;
    assign o_fwd = hz_fwd;
    assign o_stage_vld = r_q.vld;
    assign o_dec2 = r_q.dec2;
    assign o_daddr = r_q.daddr;
    assign o_dbe = r_q.dbe;
    assign o_dwdata = r_q.dwdata;
    assign o_dmisalign = r_q.dmis;

    a_exc_wide: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        r_q.in_exc |-> r_q.state == `ST_WIDE)
        else $error("handler not in wide state");
    a_exc_entry: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_exc && !r_q.in_exc) |=> (r_q.saved == $past(r_q.state)
        && r_q.flush && r_q.vld == 6'h0))
        else $error("exception entry wrong");
    a_exc_return: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_exc_ret && r_q.in_exc && !i_exc) |=>
        r_q.state == $past(r_q.saved))
        else $error("state not restored");
    a_word_fetch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        r_q.state == `ST_BYTE |-> o_iaddr[1:0] == 2'h0 && o_iword)
        else $error("bytecode fetch not word");
    a_half_align: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        r_q.state == `ST_COMPACT |-> !o_iaddr[0])
        else $error("compact fetch misaligned");
    a_byte_decode: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        r_q.dec2 |-> r_q.state == `ST_BYTE)
        else $error("second decode outside bytecode");
    a_wide_depth: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (r_q.state != `ST_BYTE && $stable(r_q.state)) |-> !r_q.vld[5])
        else $error("sixth stage in five-stage state");
    a_bx_switch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_bx && r_q.state == `ST_WIDE && i_target_lsb && !i_exc
        && !r_q.in_exc && !i_exc_ret) |=> r_q.state == `ST_COMPACT
        && r_q.flush)
        else $error("exchange did not switch");
    a_load_stall: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_src_vld && i_ex_wr && i_ex_load && i_src == i_ex_dst)
        |-> o_stall && !o_ireq)
        else $error("load hazard not stalled");
endmodule

/* File: cpu_state_pipeline_control_tb.sv */
// Purpose: Self-checking bench for the instruction state control
// Assumes: Inputs change on the falling edge
// Notes: Expected values come from state, hazard and alignment rules only
module cpu_state_pipeline_control_tb
    import pipe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk, i_rst_n, i_ibus_ready, i_bx, i_blx, i_pc_load;
    logic i_bytecode_br, i_target_lsb, i_exc, i_exc_ret, i_src_vld;
    logic i_ex_wr, i_ex_load, i_mem_wr, i_dreq, hold, bad;
    logic [31:0] i_target, i_daddr, i_dwdata;
    logic [3:0] i_src, i_ex_dst, i_mem_dst;
    size_t i_dsize;
    logic [31:0] o_iaddr, o_daddr, o_dwdata;
    logic o_ireq, o_iword, o_in_exc, o_flush, o_stall, o_dec2, o_dmisalign;
    istate_t o_state;
    logic [1:0] o_fwd;
    logic [5:0] o_stage_vld;
    logic [3:0] o_dbe;
    int n_mismatch = 0;
    int total_checks = 0;

    cpu_state_pipeline_control i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_ibus_ready(i_ibus_ready), .i_bx(i_bx), .i_blx(i_blx),
        .i_pc_load(i_pc_load), .i_bytecode_br(i_bytecode_br),
        .i_target_lsb(i_target_lsb), .i_target(i_target), .i_exc(i_exc),
        .i_exc_ret(i_exc_ret), .i_src(i_src), .i_src_vld(i_src_vld),
        .i_ex_dst(i_ex_dst), .i_ex_wr(i_ex_wr), .i_ex_load(i_ex_load),
        .i_mem_dst(i_mem_dst), .i_mem_wr(i_mem_wr), .i_dreq(i_dreq),
        .i_daddr(i_daddr), .i_dsize(i_dsize), .i_dwdata(i_dwdata),
        .o_iaddr(o_iaddr), .o_ireq(o_ireq), .o_iword(o_iword),
        .o_state(o_state), .o_in_exc(o_in_exc), .o_flush(o_flush),
        .o_stall(o_stall), .o_fwd(o_fwd), .o_stage_vld(o_stage_vld),
        .o_dec2(o_dec2), .o_daddr(o_daddr), .o_dbe(o_dbe),
        .o_dwdata(o_dwdata), .o_dmisalign(o_dmisalign));

    mem_bus_model i_mem (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hold(hold),
        .i_ireq(o_ireq), .i_iaddr(o_iaddr), .i_iword(o_iword),
        .i_state(o_state), .o_ibus_ready(i_ibus_ready), .o_bad(bad));

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    task automatic tick;
        @(negedge i_mclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Pulse {exc, exc_ret, bx, blx, pc_load, bytecode_br} for one cycle
    task automatic ctl(input logic [5:0] p, input logic lsb,
                       input logic [31:0] t);
        {i_exc, i_exc_ret, i_bx, i_blx, i_pc_load, i_bytecode_br} = p;
        i_target_lsb = lsb;
        i_target = t;
        tick();
        {i_exc, i_exc_ret, i_bx, i_blx, i_pc_load, i_bytecode_br} = 6'h00;
    endtask

    // State, flush and fetch address seen after a control pulse
    task automatic after(input logic [1:0] st, input logic fl,
                         input logic [31:0] ia);
        chk("state", {30'h0, st}, {30'h0, o_state});
        chk("flush", {31'h0, fl}, {31'h0, o_flush});
        chk("iaddr", ia, o_iaddr);
    endtask

    // One accepted fetch, then the address must have moved by the step
    task automatic step(input logic [31:0] ia);
        hold = 1'b0;
        tick();
        hold = 1'b1;
        chk("iaddr step", ia, o_iaddr);
    endtask

    task automatic t_reset;
        after(2'h0, 1'b0, 32'h00000000);
        chk("in_exc", 32'h0, {31'h0, o_in_exc});
        chk("ireq", 32'h1, {31'h0, o_ireq});
        $display("test reset done");
    endtask

    task automatic t_exchange;
        ctl(6'h08, 1'b1, 32'h00000103);
        after(2'h1, 1'b1, 32'h00000102);
        tick();
        chk("flush end", 32'h0, {31'h0, o_flush});
        step(32'h00000104);
        ctl(6'h04, 1'b0, 32'h00000208);
        after(2'h0, 1'b1, 32'h00000208);
        step(32'h0000020c);
        ctl(6'h02, 1'b1, 32'h00000030);
        after(2'h1, 1'b1, 32'h00000030);
        ctl(6'h01, 1'b0, 32'h00000040);
        after(2'h1, 1'b0, 32'h00000030);
        ctl(6'h08, 1'b0, 32'h00000040);
        after(2'h0, 1'b1, 32'h00000040);
        $display("test exchange done");
    endtask

    task automatic t_exc;
        ctl(6'h08, 1'b1, 32'h00000100);
        ctl(6'h20, 1'b0, 32'h00000000);
        after(2'h0, 1'b1, 32'h00000018);
        chk("in_exc", 32'h1, {31'h0, o_in_exc});
        chk("stage_vld", 32'h0, {26'h0, o_stage_vld});
        ctl(6'h20, 1'b0, 32'h00000000);
        after(2'h0, 1'b0, 32'h00000018);
        ctl(6'h10, 1'b0, 32'h00000206);
        after(2'h1, 1'b1, 32'h00000206);
        chk("in_exc", 32'h0, {31'h0, o_in_exc});
        ctl(6'h10, 1'b0, 32'h00000400);
        after(2'h1, 1'b0, 32'h00000206);
        ctl(6'h08, 1'b0, 32'h00000000);
        $display("test exception done");
    endtask

    task automatic t_bytecode;
        int n;
        ctl(6'h01, 1'b0, 32'h00001003);
        after(2'h2, 1'b1, 32'h00001000);
        chk("iword", 32'h1, {31'h0, o_iword});
        ctl(6'h08, 1'b1, 32'h00000500);
        after(2'h2, 1'b0, 32'h00001000);
        ctl(6'h20, 1'b0, 32'h00000000);
        after(2'h0, 1'b1, 32'h00000018);
        ctl(6'h10, 1'b0, 32'h00001005);
        after(2'h2, 1'b1, 32'h00001004);
        hold = 1'b0;
        n = 0;
        while (o_dec2 !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        chk("dec2 seen", 32'h1, {31'h0, o_dec2});
        hold = 1'b1;
        ctl(6'h01, 1'b0, 32'h00000080);
        after(2'h0, 1'b1, 32'h00000080);
        hold = 1'b0;
        for (n = 0; n < 20; n++) begin
            tick();
            chk("dec2 wide", 32'h0, {31'h0, o_dec2});
        end
        hold = 1'b1;
        $display("test bytecode done");
    endtask

    task automatic hz(input logic [5:0] v, input logic st,
                      input logic [1:0] fw);
        {i_src_vld, i_ex_wr, i_ex_load, i_mem_wr, i_ex_dst, i_mem_dst}
            = {v[5:2], 4'h3, v[1] ? 4'h3 : 4'h4};
        i_src = v[0] ? 4'h3 : 4'h5;
        #1;
        chk("stall", {31'h0, st}, {31'h0, o_stall});
        chk("ireq", {31'h0, !st}, {31'h0, o_ireq});
        chk("fwd", {30'h0, fw}, {30'h0, o_fwd});
        tick();
    endtask

    task automatic t_hazard;
        // Bits: src_vld, ex_wr, ex_load, mem_wr, mem hits, src hits
        hz(6'h3b, 1'b1, 2'h0);
        hz(6'h37, 1'b0, 2'h1);
        hz(6'h27, 1'b0, 2'h2);
        hz(6'h25, 1'b0, 2'h0);
        hz(6'h07, 1'b0, 2'h0);
        hz(6'h00, 1'b0, 2'h0);
        $display("test hazard done");
    endtask

    task automatic dat(input size_t sz, input logic [31:0] a,
                       input logic [31:0] wd, input logic [3:0] be,
                       input logic [31:0] we, input logic mis);
        i_dreq = 1'b1;
        i_dsize = sz;
        i_daddr = a;
        i_dwdata = wd;
        tick();
        chk("daddr", a, o_daddr);
        chk("misalign", {31'h0, mis}, {31'h0, o_dmisalign});
        chk("dbe", {28'h0, be}, {28'h0, o_dbe});
        chk("dwdata", we, o_dwdata);
    endtask

    task automatic t_data;
        for (int k = 0; k < 4; k++) begin
            dat(2'h0, 32'h00002000 + k, 32'h000000ab, 4'h1 << k,
                32'habababab, 1'b0);
        end
        dat(2'h1, 32'h00002000, 32'h00001234, 4'h3, 32'h12341234, 1'b0);
        dat(2'h1, 32'h00002002, 32'h00001234, 4'hc, 32'h12341234, 1'b0);
        dat(2'h2, 32'h00002004, 32'hcafe0123, 4'hf, 32'hcafe0123, 1'b0);
        dat(2'h1, 32'h00002001, 32'h00001234, 4'h3, 32'h12341234, 1'b1);
        dat(2'h2, 32'h00002002, 32'h00005678, 4'hf, 32'h00005678, 1'b1);
        i_dreq = 1'b0;
        $display("test data done");
    endtask

    initial begin
        {i_bx, i_blx, i_pc_load, i_bytecode_br, i_exc, i_exc_ret} = 6'h00;
        {i_target_lsb, i_src_vld, i_ex_wr, i_ex_load, i_mem_wr} = 5'h00;
        {i_src, i_ex_dst, i_mem_dst} = 12'h000;
        {i_target, i_daddr, i_dwdata} = 96'h0;
        i_dsize = 2'h0;
        i_dreq = 1'b0;
        hold = 1'b1;
        i_rst_n = 1'b0;
        repeat (6) tick();
        t_reset();
        i_rst_n = 1'b1;
        tick();
        t_exchange();
        t_exc();
        t_bytecode();
        t_hazard();
        t_data();
        chk("fetch alignment", 32'h0, {31'h0, bad});
        summarize();
    end
endmodule

/* File: data_align.sv */
// Purpose: Byte lane strobes and write data replication for data access
// Assumes: Requester keeps its addresses aligned
// Notes: Misaligned requests are flagged, not corrected
`include "pipe_consts.svh"
module data_align
    import pipe_pkg::*;
(
    input wire logic [1:0] i_addr_lo,   // Low address bits
    input wire size_t i_size,           // Access size
    input wire logic [31:0] i_wdata,    // Raw write data
    output logic [3:0] o_be,            // Byte enables
    output logic [31:0] o_wdata,        // Lane placed data
    output logic o_misalign             // Bad alignment seen
);
    always_comb begin
        o_be = 4'h0;
        o_wdata = i_wdata;
        o_misalign = 1'b0;
        unique case (i_size)
            `SZ_BYTE: begin
                o_be = 4'h1 << i_addr_lo;
                o_wdata = {4{i_wdata[7:0]}};
            end
            `SZ_HALF: begin
                o_be = i_addr_lo[1] ? 4'hc : 4'h3;
                o_wdata = {2{i_wdata[15:0]}};
                o_misalign = i_addr_lo[0];
            end
            default: begin
                o_be = 4'hf;
                o_misalign = |i_addr_lo;
            end
        endcase
    end
endmodule

/* File: hazard_unit.sv */
// Purpose: Detect register hazards against execute and memory stages
// Assumes: Register 0 to 15 numbering, write valid flags
// Notes: Execute-stage load results stall, others forward
module hazard_unit (
    input wire logic [3:0] i_src,       // Source register
    input wire logic i_src_vld,         // Source used
    input wire logic [3:0] i_ex_dst,    // Execute stage target
    input wire logic i_ex_wr,           // Execute writes
    input wire logic i_ex_load,         // Execute is a load
    input wire logic [3:0] i_mem_dst,   // Memory stage target
    input wire logic i_mem_wr,          // Memory writes
    output logic o_stall,               // Stall request
    output logic [1:0] o_fwd            // 1 ex, 2 mem, 0 none
);
    function automatic logic hit(input logic [3:0] a, input logic [3:0] b,
                                 input logic w, input logic v);
        hit = w && v && (a == b);
    endfunction
    always_comb begin
        o_stall = 1'b0;
        o_fwd = 2'h0;
        if (hit(i_src, i_ex_dst, i_ex_wr, i_src_vld)) begin
            if (i_ex_load) begin
                o_stall = 1'b1;
            end else begin
                o_fwd = 2'h1;
            end
        end else if (hit(i_src, i_mem_dst, i_mem_wr, i_src_vld)) begin
            o_fwd = 2'h2;
        end
    end
endmodule

/* File: mem_bus_model.sv */
// Purpose: Instruction bus partner that accepts fetches and audits them
// Assumes: One-cycle memory, hold input stalls the bus
// Notes: o_bad is sticky once any accepted fetch breaks alignment
`include "pipe_consts.svh"
module mem_bus_model
    import pipe_pkg::*;
(
    input wire logic i_mclk,            // Core clock
    input wire logic i_rst_n,           // Async reset, low
    input wire logic i_hold,            // Stall the bus
    input wire logic i_ireq,            // Fetch request
    input wire logic [31:0] i_iaddr,    // Fetch address
    input wire logic i_iword,           // Whole word fetch
    input wire istate_t i_state,        // Current state
    output logic o_ibus_ready,          // Fetch accepted
    output logic o_bad                  // Bad fetch seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bad_now;

    // Slow answers come from holding ready low
    assign o_ibus_ready = ~i_hold;

    always_comb begin
        case (i_state)
            `ST_WIDE: bad_now = i_iaddr[1:0] != 2'h0;
            `ST_COMPACT: bad_now = i_iaddr[0];
            default: bad_now = (i_iaddr[1:0] != 2'h0) || !i_iword;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bad <= 1'b0;
        end else if (i_ireq && o_ibus_ready && bad_now) begin
            o_bad <= 1'b1;
        end
    end
endmodule

/* File: pipe_consts.svh */
// Purpose: Constants for the instruction state pipeline control
// Assumes: Included by its bare name
// Notes: Operation list below
// Operation
// - Wide state: 32-bit word-aligned instructions
// - Compact state: 16-bit halfword-aligned instructions
// - Bytecode state: variable length, any byte
// - Bytecode fetches are always full words
// - Exchange branches or pc loads swap wide/compact
// - Wide/bytecode swap only by bytecode branch
// - Exceptions entered, handled, exited in wide
// - Exception in compact/bytecode reverts to wide
// - Exception return restores saved state
// - Wide/compact use five one-cycle stages
// - Bytecode uses six stages, two decode
// - Data path moves bytes, halfwords, words
// - Pending writes stall or forward
`ifndef PIPE_CONSTS_SVH
`define PIPE_CONSTS_SVH
`define ST_WIDE 2'h0
`define ST_COMPACT 2'h1
`define ST_BYTE 2'h2
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
`define WIDE_STEP 32'h00000004
`define COMPACT_STEP 32'h00000002
`define RESET_PC 32'h00000000
`define EXC_VECTOR 32'h00000018
`define WIDE_DEPTH 3'h5
`define BYTE_DEPTH 3'h6
`endif

/* File: pipe_pkg.sv */
// Purpose: Types for the instruction state pipeline control
// Assumes: Nothing
// Notes: Constants live in pipe_consts.svh
package pipe_pkg;
    typedef logic [1:0] istate_t;
    typedef logic [1:0] size_t;
endpackage
